//--- design/flash_host_pkg.sv
package flash_host_pkg;

    // Clock rate and bus cycle timing.
    localparam int CLK_MHZ         = 25;
    localparam int GLITCH_NS       = 5;
    localparam int WE_PULSE_NS     = 40;
    localparam int READ_ACCESS_NS  = 90;
    localparam int SETTLE_NS       = 1000;
    localparam int STROBE_MIN_NS   = (WE_PULSE_NS > GLITCH_NS) ? WE_PULSE_NS : GLITCH_NS + 1;
    localparam int WE_CYC          = (STROBE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int RD_CYC          = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_CYC      = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETUP_CYC       = 1;
    localparam int RECOV_CYC       = 1;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_ADDR    = 8'h04;
    localparam logic [7:0] OFS_WDATA   = 8'h08;
    localparam logic [7:0] OFS_CMD     = 8'h0c;
    localparam logic [7:0] OFS_STATUS  = 8'h10;
    localparam logic [7:0] OFS_RDATA   = 8'h14;

    // Command register codes.
    localparam logic [2:0] CMD_WRITE   = 3'h1;
    localparam logic [2:0] CMD_READ    = 3'h2;
    localparam logic [2:0] CMD_TOGGLE  = 3'h3;
    localparam logic [2:0] CMD_POLL    = 3'h4;
    localparam logic [2:0] CMD_RESET   = 3'h5;

    // Status register bit positions.
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_OK_BIT    = 1;
    localparam int ST_FAIL_BIT  = 2;
    localparam int ST_ABORT_BIT = 3;
    localparam int ST_RB_BIT    = 4;
    localparam int ST_TMO_BIT   = 5;
    localparam int ST_INTR_BIT  = 6;

    // Device status bits on the data bus.
    localparam int POLL_BIT     = 7;
    localparam int TOGGLE_P_BIT = 6;
    localparam int TOGGLE_S_BIT = 2;
    localparam int ABORT_BIT    = 1;

    // Reset values.
    localparam logic       WP_RESET    = 1'b1;

endpackage

//--- design/flash_bus_cycle.sv
`timescale 1ns/100ps
`default_nettype none
module flash_bus_cycle
    import flash_host_pkg::*;
#(
    parameter int AW = 22,
    parameter int DW = 16
) (
    // Clock and reset
    input  wire logic          core_clk_i,
    input  wire logic          arst_n_i,
    // Cycle request
    input  wire logic          start_i,
    input  wire logic          write_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] wdata_i,
    output logic               done_o,
    output logic [DW-1:0]      rdata_o,
    // Flash pins
    output logic [AW-1:0]      flash_addr_o,
    input  wire logic [DW-1:0] flash_dq_i,
    output logic [DW-1:0]      flash_dq_o,
    output logic               flash_dq_oe_o,
    output logic               flash_ce_n_o,
    output logic               flash_oe_n_o,
    output logic               flash_we_n_o
);

    typedef enum logic [1:0] {
        B_IDLE   = 2'b00,
        B_SETUP  = 2'b01,
        B_STROBE = 2'b10,
        B_RECOV  = 2'b11
    } bus_state_e;

    bus_state_e state_reg;
    logic [7:0] cnt_reg;
    logic       write_reg;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg     <= B_IDLE;
            cnt_reg       <= 8'h00;
            write_reg     <= 1'b0;
            done_o        <= 1'b0;
            rdata_o       <= '0;
            flash_addr_o  <= '0;
            flash_dq_o    <= '0;
            flash_dq_oe_o <= 1'b0;
            flash_ce_n_o  <= 1'b1;
            flash_oe_n_o  <= 1'b1;
            flash_we_n_o  <= 1'b1;
        end else begin
            done_o <= 1'b0;
            case (state_reg)
                B_IDLE: begin
                    if (start_i) begin
                        write_reg     <= write_i;
                        flash_addr_o  <= addr_i;
                        flash_dq_o    <= wdata_i;
                        flash_dq_oe_o <= write_i;
                        flash_ce_n_o  <= 1'b0;
                        cnt_reg       <= 8'(SETUP_CYC - 1);
                        state_reg     <= B_SETUP;
                    end
                end
                B_SETUP: begin
                    if (cnt_reg == 8'h00) begin
                        // Only one strobe falls; OE stays high through a write.
                        flash_we_n_o <= !write_reg;
                        flash_oe_n_o <= write_reg;
                        cnt_reg      <= write_reg ? 8'(WE_CYC - 1) : 8'(RD_CYC - 1);
                        state_reg    <= B_STROBE;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                B_STROBE: begin
                    if (cnt_reg == 8'h00) begin
                        if (!write_reg) begin
                            rdata_o <= flash_dq_i;
                        end
                        flash_we_n_o <= 1'b1;
                        flash_oe_n_o <= 1'b1;
                        cnt_reg      <= 8'(RECOV_CYC - 1);
                        state_reg    <= B_RECOV;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                B_RECOV: begin
                    if (cnt_reg == 8'h00) begin
                        // Chip select rises between cycles so each read completes.
                        flash_ce_n_o  <= 1'b1;
                        flash_dq_oe_o <= 1'b0;
                        done_o        <= 1'b1;
                        state_reg     <= B_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                default: begin
                    state_reg <= B_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

//--- design/flash_status_host.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Wait one microsecond before trusting full word
// - Status reads use monitored operation's address
// - On completion read twice more to confirm
// - Reset pulse, then recovery before reads
// - Flag operations interrupted by hardware reset
// - Abort reported until software sends the next command
module flash_status_host
    import flash_host_pkg::*;
#(
    parameter int AW               = 22,
    parameter int DW               = 16,
    parameter int RESET_PULSE_NS   = 500,
    parameter int RESET_RECOV_NS   = 1000,
    parameter int POLL_LIMIT       = 65535
) (
    // Clock and reset
    input  wire logic          core_clk_i,
    input  wire logic          arst_n_i,
    // Register port
    input  wire logic [7:0]    reg_addr_i,
    input  wire logic [31:0]   reg_wdata_i,
    input  wire logic          reg_wr_i,
    input  wire logic          reg_rd_i,
    output logic [31:0]        reg_rdata_o,
    // Flash pins
    output logic [AW-1:0]      flash_addr_o,
    input  wire logic [DW-1:0] flash_dq_i,
    output logic [DW-1:0]      flash_dq_o,
    output logic               flash_dq_oe_o,
    output logic               flash_ce_n_o,
    output logic               flash_oe_n_o,
    output logic               flash_we_n_o,
    output logic               flash_wp_n_o,
    output logic               flash_rst_n_o,
    input  wire logic          ready_busy_n_i
);

    localparam int RST_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int REC_CYC = (RESET_RECOV_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [3:0] {
        S_IDLE     = 4'b0000,
        S_CYCLE    = 4'b0001,
        S_PREAD    = 4'b0010,
        S_PEVAL    = 4'b0011,
        S_SETTLE   = 4'b0100,
        S_CREAD    = 4'b0101,
        S_CEVAL    = 4'b0110,
        S_RSTLOW   = 4'b0111,
        S_RSTREC   = 4'b1000
    } host_state_e;

    host_state_e   state_reg;
    logic          wp_reg;
    logic [AW-1:0] addr_reg;
    logic [DW-1:0] wdata_reg;
    logic [DW-1:0] rdata_reg;
    logic [DW-1:0] first_reg;
    logic [2:0]    op_reg;
    logic          issued_reg;
    logic          nread_reg;
    logic [15:0]   wait_reg;
    logic [15:0]   poll_cnt_reg;
    logic          ok_reg;
    logic          fail_reg;
    logic          abort_reg;
    logic          tmo_reg;
    logic          intr_reg;
    logic          bus_start;
    logic          bus_write;
    logic          bus_done;
    logic [DW-1:0] bus_rdata;
    logic          cmd_go;
    logic          reading;
    logic          pair_differs;
    logic          poll_match;

    assign cmd_go  = reg_wr_i && (reg_addr_i == OFS_CMD) && (state_reg == S_IDLE);
    assign reading = (state_reg == S_PREAD) || (state_reg == S_CREAD);
    assign bus_start = !issued_reg && (reading || state_reg == S_CYCLE);
    assign bus_write = (state_reg == S_CYCLE) && (op_reg == CMD_WRITE);
    assign pair_differs = first_reg[TOGGLE_P_BIT] != bus_rdata[TOGGLE_P_BIT];
    assign poll_match   = bus_rdata[POLL_BIT] == wdata_reg[POLL_BIT];

    flash_bus_cycle #(
        .AW (AW),
        .DW (DW)
    ) u_bus (
        .core_clk_i    (core_clk_i),
        .arst_n_i      (arst_n_i),
        .start_i       (bus_start),
        .write_i       (bus_write),
        .addr_i        (addr_reg),
        .wdata_i       (wdata_reg),
        .done_o        (bus_done),
        .rdata_o       (bus_rdata),
        .flash_addr_o  (flash_addr_o),
        .flash_dq_i    (flash_dq_i),
        .flash_dq_o    (flash_dq_o),
        .flash_dq_oe_o (flash_dq_oe_o),
        .flash_ce_n_o  (flash_ce_n_o),
        .flash_oe_n_o  (flash_oe_n_o),
        .flash_we_n_o  (flash_we_n_o)
    );

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wp_reg    <= WP_RESET;
            addr_reg  <= '0;
            wdata_reg <= '0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                OFS_CTRL:  wp_reg    <= reg_wdata_i[0];
                OFS_ADDR:  addr_reg  <= reg_wdata_i[AW-1:0];
                OFS_WDATA: wdata_reg <= reg_wdata_i[DW-1:0];
                default: begin
                end
            endcase
        end
    end

    assign flash_wp_n_o = wp_reg;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                OFS_CTRL:   reg_rdata_o <= {31'h0000_0000, wp_reg};
                OFS_ADDR:   reg_rdata_o <= 32'(addr_reg);
                OFS_WDATA:  reg_rdata_o <= 32'(wdata_reg);
                OFS_STATUS: reg_rdata_o <= {25'h000_0000, intr_reg, tmo_reg, ready_busy_n_i,
                                            abort_reg, fail_reg, ok_reg, state_reg != S_IDLE};
                OFS_RDATA:  reg_rdata_o <= 32'(rdata_reg);
                default:    reg_rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            issued_reg <= 1'b0;
        end else if (bus_done) begin
            issued_reg <= 1'b0;
        end else if (bus_start) begin
            issued_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_reg <= '0;
            first_reg <= '0;
        end else if (bus_done && !bus_write) begin
            rdata_reg <= bus_rdata;
            if (!nread_reg) begin
                first_reg <= bus_rdata;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg     <= S_IDLE;
            op_reg        <= 3'h0;
            nread_reg     <= 1'b0;
            wait_reg      <= 16'h0000;
            poll_cnt_reg  <= 16'h0000;
            ok_reg        <= 1'b0;
            fail_reg      <= 1'b0;
            abort_reg     <= 1'b0;
            tmo_reg       <= 1'b0;
            intr_reg      <= 1'b0;
            flash_rst_n_o <= 1'b1;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (cmd_go) begin
                        op_reg       <= reg_wdata_i[2:0];
                        nread_reg    <= 1'b0;
                        poll_cnt_reg <= 16'h0000;
                        ok_reg       <= 1'b0;
                        fail_reg     <= 1'b0;
                        abort_reg    <= 1'b0;
                        tmo_reg      <= 1'b0;
                        case (reg_wdata_i[2:0])
                            CMD_WRITE, CMD_READ: state_reg <= S_CYCLE;
                            // Polling starts only after the launching strobe.
                            CMD_TOGGLE, CMD_POLL: state_reg <= S_PREAD;
                            CMD_RESET: begin
                                intr_reg      <= !ready_busy_n_i;
                                flash_rst_n_o <= 1'b0;
                                wait_reg      <= 16'(RST_CYC - 1);
                                state_reg     <= S_RSTLOW;
                            end
                            default: state_reg <= S_IDLE;
                        endcase
                    end
                end
                S_CYCLE: begin
                    if (bus_done) begin
                        state_reg <= S_IDLE;
                    end
                end
                S_PREAD: begin
                    if (bus_done) begin
                        nread_reg <= !nread_reg;
                        if (op_reg == CMD_POLL || nread_reg) begin
                            state_reg <= S_PEVAL;
                        end
                    end
                end
                S_PEVAL: begin
                    nread_reg <= 1'b0;
                    if ((op_reg == CMD_POLL) ? poll_match : !pair_differs) begin
                        wait_reg  <= 16'(SETTLE_CYC - 1);
                        state_reg <= S_SETTLE;
                    end else if (bus_rdata[ABORT_BIT]) begin
                        abort_reg <= 1'b1;
                        state_reg <= S_IDLE;
                    end else if (poll_cnt_reg == 16'(POLL_LIMIT)) begin
                        tmo_reg   <= 1'b1;
                        state_reg <= S_IDLE;
                    end else begin
                        poll_cnt_reg <= poll_cnt_reg + 16'h0001;
                        state_reg    <= S_PREAD;
                    end
                end
                S_SETTLE: begin
                    if (wait_reg == 16'h0000) begin
                        state_reg <= S_CREAD;
                    end else begin
                        wait_reg <= wait_reg - 16'h0001;
                    end
                end
                S_CREAD: begin
                    if (bus_done) begin
                        nread_reg <= !nread_reg;
                        if (nread_reg) begin
                            state_reg <= S_CEVAL;
                        end
                    end
                end
                S_CEVAL: begin
                    // Two more reads must agree and show completion.
                    nread_reg <= 1'b0;
                    state_reg <= S_IDLE;
                    if (first_reg == bus_rdata && (op_reg != CMD_POLL || poll_match)) begin
                        ok_reg <= 1'b1;
                    end else begin
                        fail_reg <= 1'b1;
                    end
                end
                S_RSTLOW: begin
                    if (wait_reg == 16'h0000) begin
                        flash_rst_n_o <= 1'b1;
                        wait_reg      <= 16'(REC_CYC - 1);
                        state_reg     <= S_RSTREC;
                    end else begin
                        wait_reg <= wait_reg - 16'h0001;
                    end
                end
                S_RSTREC: begin
                    if (wait_reg == 16'h0000) begin
                        state_reg <= S_IDLE;
                    end else begin
                        wait_reg <= wait_reg - 16'h0001;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

//--- testbench/flash_status_host_checker.sv
`timescale 1ns/100ps
`default_nettype none
module flash_status_host_checker
    import flash_host_pkg::*;
#(
    parameter int RESET_PULSE_NS = 500,
    parameter int RESET_RECOV_NS = 1000
) (
    // Clock and reset
    input wire logic        core_clk_i,
    input wire logic        arst_n_i,
    // Register port
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // Flash pins
    input wire logic [15:0] flash_dq_o,
    input wire logic        flash_dq_oe_o,
    input wire logic        flash_ce_n_o,
    input wire logic        flash_oe_n_o,
    input wire logic        flash_we_n_o,
    input wire logic        flash_wp_n_o,
    input wire logic        flash_rst_n_o,
    input wire logic        ready_busy_n_i
);
    localparam int RST_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int REC_CYC = (RESET_RECOV_NS * CLK_MHZ + 999) / 1000;
    logic [7:0] low_cnt;
    logic [7:0] since_rst;

    // Reset pulse length and cycles since release, saturating.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            low_cnt   <= 8'h00;
            since_rst <= 8'hff;
        end else if (!flash_rst_n_o) begin
            low_cnt   <= low_cnt + {7'h00, low_cnt != 8'hff};
            since_rst <= 8'h00;
        end else begin
            low_cnt   <= 8'h00;
            since_rst <= since_rst + {7'h00, since_rst != 8'hff};
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    AST_WE_QUALIFIED: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o && flash_dq_oe_o)
        else $error("write strobe not qualified");
    AST_WE_PULSE: assert property ($fell(flash_we_n_o) |=>
        flash_we_n_o && !flash_ce_n_o && flash_dq_oe_o && $stable(flash_dq_o) ##1 flash_ce_n_o)
        else $error("bad write pulse shape");
    AST_NO_CONTENTION: assert property (!flash_oe_n_o |-> !flash_dq_oe_o && !flash_ce_n_o && flash_we_n_o)
        else $error("bus contention on read");
    AST_RD_OE_LEN: assert property ($fell(flash_oe_n_o) |-> !flash_oe_n_o [*3] ##1 flash_oe_n_o)
        else $error("read enable length wrong");
    AST_RD_RECOVER: assert property ($rose(flash_oe_n_o) |-> !flash_ce_n_o ##1 flash_ce_n_o)
        else $error("read cycle not closed");
    AST_RST_PULSE: assert property ($rose(flash_rst_n_o) |-> low_cnt >= RST_CYC)
        else $error("reset pulse too short");
    AST_RST_RECOVER: assert property (!flash_ce_n_o |-> since_rst >= REC_CYC)
        else $error("cycle before reset recovery");
    AST_WP_LEVEL: assert property (reg_wr_i && reg_addr_i == OFS_CTRL |=>
        flash_wp_n_o == $past(reg_wdata_i[0]))
        else $error("write protect level wrong");
    AST_RB_STATUS: assert property (reg_rd_i && reg_addr_i == OFS_STATUS |=>
        reg_rdata_o[ST_RB_BIT] == $past(ready_busy_n_i))
        else $error("ready busy status wrong");
    AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data not zero");
endmodule
`default_nettype wire

//--- testbench/flash_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
    parameter logic [21:0] BOOT_TOP = 22'h008000
) (
    // Bus pins
    input wire logic [21:0] addr_i,
    input wire logic [15:0] host_dq_i,
    input wire logic        host_dq_oe_i,
    input wire logic        ce_n_i,
    input wire logic        oe_n_i,
    input wire logic        we_n_i,
    input wire logic        wp_n_i,
    input wire logic        rst_n_i,
    // Scenario controls
    input wire logic        erase_i,
    input wire logic        abort_i,
    input wire logic [7:0]  busy_len_i,
    // Observed
    output logic [15:0]     dq_o,
    output logic            rb_low_o,
    output logic [7:0]      wr_count_o,
    output logic [15:0]     last_data_o
);
    logic [15:0] mem = 16'hffff;
    logic [15:0] last_q = 16'h0000;
    logic [15:0] dev_out;
    logic [7:0]  busy_cnt = 8'h00;
    logic        tog_p = 1'b0;
    logic        tog_s = 1'b0;
    logic        aborted = 1'b0;
    logic        erase_op = 1'b0;

    initial begin
        wr_count_o = 8'h00;
        last_data_o = 16'h0000;
    end

    always_comb begin
        dev_out = mem;
        if (busy_cnt != 8'h00) begin
            dev_out = ~mem;
            dev_out[7] = erase_op ? 1'b0 : ~mem[7];
            dev_out[6] = tog_p;
            dev_out[2] = tog_s;
            dev_out[1] = aborted;
        end
    end

    // A released bus shows the inverse of the last word.
    assign dq_o = host_dq_oe_i ? host_dq_i : (!ce_n_i && !oe_n_i) ? dev_out : ~last_q;
    assign rb_low_o = busy_cnt != 8'h00;

    always @(negedge rst_n_i) begin
        busy_cnt = 8'h00;
        aborted = 1'b0;
    end

    always @(posedge we_n_i) begin
        if (!ce_n_i && oe_n_i && rst_n_i) begin
            wr_count_o = wr_count_o + 8'h01;
            last_data_o = host_dq_i;
            if (busy_cnt == 8'h00 && !(!wp_n_i && addr_i < BOOT_TOP)) begin
                busy_cnt = busy_len_i;
                erase_op = erase_i;
                aborted = abort_i;
                mem = erase_i ? 16'hffff : host_dq_i;
            end
        end
    end

    // Aborted operations stay busy until reset.
    always @(posedge oe_n_i) begin
        if (!ce_n_i) begin
            last_q = dev_out;
            if (busy_cnt != 8'h00) begin
                tog_p = ~tog_p;
                tog_s = tog_s ^ erase_op;
                busy_cnt = aborted ? busy_cnt : busy_cnt - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/test_flash_status_host.sv
`timescale 1ns/100ps
`default_nettype none
module test_flash_status_host
    import flash_host_pkg::*;
();
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata, st, d;
    logic [21:0] f_addr;
    logic [15:0] f_dq_out, f_dq_in, last_data;
    logic        f_dq_oe, f_ce_n, f_oe_n, f_we_n, f_wp_n, f_rst_n, rb_low, ready_busy_n;
    logic        m_erase = 1'b0;
    logic        m_abort = 1'b0;
    logic [7:0]  m_len = 8'h02;
    logic [7:0]  wr_count;
    int          err_count = 0;
    int          check_count = 0;
    localparam logic [31:0] OK_RB = (32'h1 << ST_OK_BIT) | (32'h1 << ST_RB_BIT);

    always #20 core_clk = ~core_clk;
    // Open-drain line with an external pull-up.
    assign ready_busy_n = rb_low ? 1'b0 : 1'b1;

    flash_status_host #(.POLL_LIMIT(4)) dut_u (
        .core_clk_i(core_clk), .arst_n_i(arst_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .flash_addr_o(f_addr),
        .flash_dq_i(f_dq_in), .flash_dq_o(f_dq_out), .flash_dq_oe_o(f_dq_oe), .flash_ce_n_o(f_ce_n),
        .flash_oe_n_o(f_oe_n), .flash_we_n_o(f_we_n), .flash_wp_n_o(f_wp_n), .flash_rst_n_o(f_rst_n),
        .ready_busy_n_i(ready_busy_n));

    flash_dev_model dev_u (
        .addr_i(f_addr), .host_dq_i(f_dq_out), .host_dq_oe_i(f_dq_oe), .ce_n_i(f_ce_n), .oe_n_i(f_oe_n),
        .we_n_i(f_we_n), .wp_n_i(f_wp_n), .rst_n_i(f_rst_n), .erase_i(m_erase), .abort_i(m_abort),
        .busy_len_i(m_len), .dq_o(f_dq_in), .rb_low_o(rb_low), .wr_count_o(wr_count), .last_data_o(last_data));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Issues a command and waits, bounded, for idle.
    task automatic run_cmd(input logic [2:0] c);
        reg_write(OFS_CMD, {29'h0, c});
        st = 32'h1;
        for (int i = 0; i < 2000 && st[ST_BUSY_BIT] !== 1'b0; i++)
            reg_read(OFS_STATUS, st);
        check({31'h0, st[ST_BUSY_BIT]}, 32'h0);
    endtask

    task automatic launch(input logic [31:0] a, input logic [15:0] w);
        reg_write(OFS_ADDR, a);
        reg_write(OFS_WDATA, {16'h0, w});
        run_cmd(CMD_WRITE);
    endtask

    task automatic test_regs();
        reg_read(OFS_STATUS, d);
        check(d, 32'h1 << ST_RB_BIT);
        reg_read(OFS_CTRL, d);
        check(d, {31'h0, WP_RESET});
        check({31'h0, f_wp_n}, 32'h1);
        reg_read(OFS_CMD, d);
        check(d, 32'h0);
        reg_read(8'h18, d);
        check(d, 32'h0);
        $display("test_regs done");
    endtask

    task automatic test_program();
        logic [15:0] w;
        logic [7:0]  n;
        m_len = 8'h03;
        for (int i = 0; i < 2; i++) begin
            w = i ? 16'h00a5 : 16'h1234;
            n = wr_count;
            launch(32'h100, w);
            check({24'h0, wr_count}, {24'h0, n + 8'h01});
            check({16'h0, last_data}, {16'h0, w});
            check({31'h0, ready_busy_n}, 32'h0);
            run_cmd(CMD_POLL);
            check(st, OK_RB);
            run_cmd(CMD_READ);
            reg_read(OFS_RDATA, d);
            check(d, {16'h0, w});
        end
        $display("test_program done");
    endtask

    task automatic test_erase();
        m_erase = 1'b1;
        m_len = 8'h04;
        for (int i = 0; i < 2; i++) begin
            launch(32'h10000, 16'h00b0);
            run_cmd(i ? CMD_POLL : CMD_TOGGLE);
            check(st, OK_RB);
            reg_read(OFS_RDATA, d);
            check(d, 32'h0000ffff);
        end
        m_erase = 1'b0;
        $display("test_erase done");
    endtask

    task automatic test_abort();
        m_abort = 1'b1;
        launch(32'h200, 16'h0011);
        run_cmd(CMD_TOGGLE);
        check(st, 32'h1 << ST_ABORT_BIT);
        m_abort = 1'b0;
        run_cmd(CMD_RESET);
        check(st, (32'h1 << ST_INTR_BIT) | (32'h1 << ST_RB_BIT));
        run_cmd(CMD_RESET);
        check(st, 32'h1 << ST_RB_BIT);
        $display("test_abort done");
    endtask

    task automatic test_protect();
        logic [21:0] at [4] = '{22'h000010, 22'h007fff, 22'h008000, 22'h000010};
        logic [3:0]  wp = 4'b1000;
        logic [3:0]  ok = 4'b1100;
        m_len = 8'h02;
        for (int i = 0; i < 4; i++) begin
            reg_write(OFS_CTRL, {31'h0, wp[i]});
            launch({10'h0, at[i]}, 16'h0080);
            check({31'h0, f_wp_n}, {31'h0, wp[i]});
            check({31'h0, ready_busy_n}, {31'h0, ~ok[i]});
            run_cmd(CMD_POLL);
            check(st, ok[i] ? OK_RB : ((32'h1 << ST_TMO_BIT) | (32'h1 << ST_RB_BIT)));
        end
        $display("test_protect done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        test_regs();
        test_program();
        test_erase();
        test_abort();
        test_protect();
        tally_and_finish();
    end

    initial begin
        #2000000;
        err_count++;
        tally_and_finish();
    end
endmodule

bind flash_status_host flash_status_host_checker #(
    .RESET_PULSE_NS(RESET_PULSE_NS), .RESET_RECOV_NS(RESET_RECOV_NS)
) chk_u (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o), .flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o),
    .flash_we_n_o(flash_we_n_o), .flash_wp_n_o(flash_wp_n_o), .flash_rst_n_o(flash_rst_n_o),
    .ready_busy_n_i(ready_busy_n_i));
`default_nettype wire
